// *** src/axm_consts.vh ***
// constants for the auxiliary i2c channel 1 and 2 block
`ifndef AXM_CONSTS_VH
`define AXM_CONSTS_VH
`define AXM_OFF_CH1_ADDR    8'h28
`define AXM_OFF_CH1_REG     8'h29
`define AXM_OFF_CH1_CTRL    8'h2A
`define AXM_OFF_CH2_ADDR    8'h2B
`define AXM_OFF_CH2_REG     8'h2C
`define AXM_OFF_CH2_CTRL    8'h2D
`define AXM_OFF_CH1_WDATA   8'h61
`define AXM_OFF_CH2_WDATA   8'h62
`define AXM_OFF_STATUS      8'h63
`define AXM_OFF_SAMPLE_BASE 8'h49
`define AXM_RST_ADDR        8'h00
`define AXM_RST_REG         8'h00
`define AXM_RST_CTRL        8'h00
`define AXM_RST_WDATA       8'h00
`define AXM_BIT_RNW         7
`define AXM_BIT_EN          7
`define AXM_BIT_SWAP        6
`define AXM_BIT_SKIPREG     5
`define AXM_BIT_GRP         4
`define AXM_ST_BUSY         0
`define AXM_ST_NACK1        1
`define AXM_ST_NACK2        2
`define AXM_CMD_START       2'h0
`define AXM_CMD_WRITE       2'h1
`define AXM_CMD_READ        2'h2
`define AXM_CMD_STOP        2'h3
`define AXM_CLK_PERIOD_NS   25
`define AXM_SCL_PERIOD_NS   2500
// quarter of the line clock period, in system clocks
`define AXM_SCL_QUARTER     16'h0019
`define AXM_SAMPLE_DEPTH    24
`endif

// *** src/axm_sync.v ***
// two-flop synchroniser for pin inputs
`default_nettype none
module axm_sync #(
	parameter WIDTH = 2
) (
	input  wire             clk,    // system clock
	input  wire             rst,    // synchronous reset
	input  wire [WIDTH-1:0] din,    // asynchronous inputs
	output reg  [WIDTH-1:0] dout    // synchronised outputs
);
	reg [WIDTH-1:0] stage1;

	always @(posedge clk) begin
		if (rst) begin
			stage1 <= {WIDTH{1'b1}};
			dout   <= {WIDTH{1'b1}};
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule
`default_nettype wire

// *** src/axm_i2c_engine.v ***
// i2c byte engine: start, byte write, byte read, stop
`include "axm_consts.vh"
`default_nettype none
module axm_i2c_engine #(
	parameter [15:0] QUARTER = `AXM_SCL_QUARTER
) (
	input  wire       clk,       // system clock
	input  wire       rst,       // synchronous reset
	input  wire       cmdValid,  // command pulse, taken when idle
	input  wire [1:0] cmdCode,   // command code
	input  wire [7:0] txByte,    // byte to write
	input  wire       ackSend,   // 1: acknowledge a read byte
	input  wire       sclIn,     // synchronised clock line
	input  wire       sdaIn,     // synchronised data line
	output reg        done,      // command finished pulse
	output reg  [7:0] rxByte,    // byte read
	output reg        ackSeen,   // target acknowledged
	output reg        sclOe,     // pull clock line low
	output reg        sdaOe      // pull data line low
);
	localparam E_IDLE  = 2'h0;
	localparam E_START = 2'h1;
	localparam E_BITS  = 2'h2;
	localparam E_STOP  = 2'h3;

	reg [1:0]  state;
	reg [1:0]  quarter;
	reg [15:0] qcnt;
	reg [3:0]  bitIdx;
	reg [7:0]  txShift;
	reg        isRead;
	reg        ackDrive;

	// target holding clock low stalls the divider
	wire stretch = !sclOe && !sclIn;
	wire tick    = (qcnt == QUARTER - 16'h0001);

	always @(posedge clk) begin
		if (rst) begin
			state    <= E_IDLE;
			quarter  <= 2'h0;
			qcnt     <= 16'h0000;
			bitIdx   <= 4'h0;
			txShift  <= 8'h00;
			isRead   <= 1'b0;
			ackDrive <= 1'b0;
			done     <= 1'b0;
			rxByte   <= 8'h00;
			ackSeen  <= 1'b0;
			sclOe    <= 1'b0;
			sdaOe    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (state == E_IDLE) begin
				if (cmdValid) begin
					qcnt    <= 16'h0000;
					quarter <= 2'h0;
					bitIdx  <= 4'h0;
					case (cmdCode)
						`AXM_CMD_START: begin
							sdaOe <= 1'b0;
							state <= E_START;
						end
						`AXM_CMD_WRITE: begin
							txShift <= txByte;
							isRead  <= 1'b0;
							state   <= E_BITS;
						end
						`AXM_CMD_READ: begin
							isRead   <= 1'b1;
							ackDrive <= ackSend;
							state    <= E_BITS;
						end
						default: state <= E_STOP;
					endcase
				end
			end else if (!stretch) begin
				if (!tick) begin
					qcnt <= qcnt + 16'h0001;
				end else begin
					qcnt    <= 16'h0000;
					quarter <= quarter + 2'h1;
					case (state)
						// start: data falls while clock high
						E_START: begin
							case (quarter)
								2'h0: sclOe <= 1'b0;
								2'h1: sdaOe <= 1'b1;
								2'h2: sclOe <= 1'b1;
								default: begin
									done  <= 1'b1;
									state <= E_IDLE;
								end
							endcase
						end
						E_BITS: begin
							case (quarter)
								2'h0: begin
									if (bitIdx == 4'h8)
										sdaOe <= isRead & ackDrive;
									else
										sdaOe <= !isRead & !txShift[7];
								end
								2'h1: sclOe <= 1'b0;
								2'h2: begin
									if (bitIdx == 4'h8)
										ackSeen <= !sdaIn;
									else
										rxByte <= {rxByte[6:0], sdaIn};
								end
								default: begin
									sclOe   <= 1'b1;
									txShift <= {txShift[6:0], 1'b0};
									if (bitIdx == 4'h8) begin
										done  <= 1'b1;
										state <= E_IDLE;
									end else begin
										bitIdx <= bitIdx + 4'h1;
									end
								end
							endcase
						end
						// stop: data rises while clock high
						default: begin
							case (quarter)
								2'h0: sdaOe <= 1'b1;
								2'h1: sclOe <= 1'b0;
								2'h2: sdaOe <= 1'b0;
								default: begin
									done  <= 1'b1;
									state <= E_IDLE;
								end
							endcase
						end
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** src/axm_aux_channels.v ***
// auxiliary i2c master, slave channels 1 and 2
//
// Design decision made here: the strobed register port.
`include "axm_consts.vh"
`default_nettype none
module axm_aux_channels #(
	parameter [15:0] SCL_QUARTER  = `AXM_SCL_QUARTER,
	parameter        SAMPLE_DEPTH = `AXM_SAMPLE_DEPTH
) (
	input  wire       mclk,          // system clock, 40 MHz
	input  wire       sys_rst,       // synchronous reset, active high
	input  wire [7:0] regAddr,       // register address
	input  wire [7:0] regWdata,      // register write data
	input  wire       regWrite,      // write strobe
	input  wire       regRead,       // read strobe
	output reg  [7:0] regRdata,      // read data, cycle after strobe
	input  wire       samplePulse,   // one pulse per sample period
	input  wire       ch0Enable,     // channel 0 enabled
	input  wire [3:0] ch0ByteCount,  // channel 0 byte count
	input  wire       sclIn,         // clock line level
	output reg        sclOut,        // clock line drive value, always 0
	output wire       sclOe,         // pull clock line low
	input  wire       sdaIn,         // data line level
	output reg        sdaOut,        // data line drive value, always 0
	output wire       sdaOe          // pull data line low
);
	localparam S_IDLE   = 4'h0;
	localparam S_SEL    = 4'h1;
	localparam S_START  = 4'h2;
	localparam S_ADDR   = 4'h3;
	localparam S_REG    = 4'h4;
	localparam S_RSTART = 4'h5;
	localparam S_RADDR  = 4'h6;
	localparam S_DATA   = 4'h7;
	localparam S_WDATA  = 4'h8;
	localparam S_STOP   = 4'h9;

	reg  [7:0] slave1TargetAddress;
	reg  [7:0] slave1StartRegister;
	reg  [7:0] slave1ChannelControl;
	reg  [7:0] slave2TargetAddress;
	reg  [7:0] slave2StartRegister;
	reg  [7:0] slave2ChannelControl;
	reg  [7:0] ch1WriteData;
	reg  [7:0] ch2WriteData;
	reg        nack1;
	reg        nack2;
	reg  [7:0] externalSampleBytes [0:SAMPLE_DEPTH-1];

	reg  [3:0] state;
	reg  [1:0] pending;
	reg        cur;
	reg        issued;
	reg        cmdValid;
	reg  [1:0] cmdCode;
	reg  [7:0] txByte;
	reg        ackSend;
	reg  [6:0] curId;
	reg        curRead;
	reg  [7:0] curStart;
	reg        curSwap;
	reg        curSkip;
	reg        curGrp;
	reg  [3:0] curCount;
	reg  [5:0] curBase;
	reg  [3:0] byteIdx;
	integer    i;

	wire [1:0] syncOut;
	wire       sclSync = syncOut[1];
	wire       sdaSync = syncOut[0];
	wire       engDone;
	wire [7:0] rxByte;
	wire       ackSeen;

	wire       ch1ReadNotWrite = slave1TargetAddress[`AXM_BIT_RNW];
	wire       ch2ReadNotWrite = slave2TargetAddress[`AXM_BIT_RNW];
	wire [6:0] ch1TargetId     = slave1TargetAddress[6:0];
	wire [6:0] ch2TargetId     = slave2TargetAddress[6:0];
	wire       ch1Enable       = slave1ChannelControl[`AXM_BIT_EN];
	wire       ch2Enable       = slave2ChannelControl[`AXM_BIT_EN];
	wire [3:0] ch1ByteCount    = slave1ChannelControl[3:0];
	wire [3:0] ch2ByteCount    = slave2ChannelControl[3:0];

	// channel 1 starts after channel 0 bytes
	wire [5:0] ch1Base = ch0Enable ? {2'b00, ch0ByteCount} : 6'h00;
	// channel 2 starts after channels 0 and 1
	wire [5:0] ch2Base = ch1Base + (ch1Enable ? {2'b00, ch1ByteCount} : 6'h00);

	// target register address of the current byte
	wire [7:0] byteRegAddr = curStart + {4'h0, byteIdx};
	wire       notLast     = ({1'b0, byteIdx} + 5'h01) < {1'b0, curCount};
	// first of a pair: even address when group 0, odd when 1
	wire       pairFirst   = (byteRegAddr[0] == curGrp);
	// swap only bytes whose partner was read
	wire       swapFirst   = curSwap && pairFirst && notLast;
	wire       swapSecond  = curSwap && !pairFirst && (byteIdx != 4'h0);
	// no adjustment when swapping is off
	wire [5:0] destIdx     = curBase + {2'b00, byteIdx}
	                         + (swapFirst ? 6'h01 : (swapSecond ? 6'h3F : 6'h00));

	wire [7:0] statusValue = {5'h00, nack2, nack1, (state != S_IDLE)};
	wire [7:0] sampleOff   = regAddr - `AXM_OFF_SAMPLE_BASE;
	wire       sampleHit   = (regAddr >= `AXM_OFF_SAMPLE_BASE) && (sampleOff < SAMPLE_DEPTH);
	wire       nackEvent   = engDone && !ackSeen &&
	                         ((state == S_ADDR) || (state == S_REG) || (state == S_RADDR));

	axm_sync #(
		.WIDTH (2)
	) u_sync (
		.clk  (mclk),
		.rst  (sys_rst),
		.din  ({sclIn, sdaIn}),
		.dout (syncOut)
	);

	axm_i2c_engine #(
		.QUARTER (SCL_QUARTER)
	) u_engine (
		.clk      (mclk),
		.rst      (sys_rst),
		.cmdValid (cmdValid),
		.cmdCode  (cmdCode),
		.txByte   (txByte),
		.ackSend  (ackSend),
		.sclIn    (sclSync),
		.sdaIn    (sdaSync),
		.done     (engDone),
		.rxByte   (rxByte),
		.ackSeen  (ackSeen),
		.sclOe    (sclOe),
		.sdaOe    (sdaOe)
	);

	// register writes and read answers
	always @(posedge mclk) begin
		if (sys_rst) begin
			slave1TargetAddress  <= `AXM_RST_ADDR;
			slave1StartRegister  <= `AXM_RST_REG;
			slave1ChannelControl <= `AXM_RST_CTRL;
			slave2TargetAddress  <= `AXM_RST_ADDR;
			slave2StartRegister  <= `AXM_RST_REG;
			slave2ChannelControl <= `AXM_RST_CTRL;
			ch1WriteData         <= `AXM_RST_WDATA;
			ch2WriteData         <= `AXM_RST_WDATA;
			nack1                <= 1'b0;
			nack2                <= 1'b0;
			regRdata             <= 8'h00;
			sclOut               <= 1'b0;
			sdaOut               <= 1'b0;
		end else begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
			if (regWrite) begin
				case (regAddr)
					`AXM_OFF_CH1_ADDR:  slave1TargetAddress  <= regWdata;
					`AXM_OFF_CH1_REG:   slave1StartRegister  <= regWdata;
					`AXM_OFF_CH1_CTRL:  slave1ChannelControl <= regWdata;
					`AXM_OFF_CH2_ADDR:  slave2TargetAddress  <= regWdata;
					`AXM_OFF_CH2_REG:   slave2StartRegister  <= regWdata;
					`AXM_OFF_CH2_CTRL:  slave2ChannelControl <= regWdata;
					`AXM_OFF_CH1_WDATA: ch1WriteData         <= regWdata;
					`AXM_OFF_CH2_WDATA: ch2WriteData         <= regWdata;
					default: ;
				endcase
			end
			// sticky nack flags: write one clears, a new nack wins
			if (nackEvent && !cur)
				nack1 <= 1'b1;
			else if (regWrite && regAddr == `AXM_OFF_STATUS && regWdata[`AXM_ST_NACK1])
				nack1 <= 1'b0;
			if (nackEvent && cur)
				nack2 <= 1'b1;
			else if (regWrite && regAddr == `AXM_OFF_STATUS && regWdata[`AXM_ST_NACK2])
				nack2 <= 1'b0;
			regRdata <= 8'h00;
			if (regRead) begin
				case (regAddr)
					`AXM_OFF_CH1_ADDR:  regRdata <= slave1TargetAddress;
					`AXM_OFF_CH1_REG:   regRdata <= slave1StartRegister;
					`AXM_OFF_CH1_CTRL:  regRdata <= slave1ChannelControl;
					`AXM_OFF_CH2_ADDR:  regRdata <= slave2TargetAddress;
					`AXM_OFF_CH2_REG:   regRdata <= slave2StartRegister;
					`AXM_OFF_CH2_CTRL:  regRdata <= slave2ChannelControl;
					`AXM_OFF_CH1_WDATA: regRdata <= ch1WriteData;
					`AXM_OFF_CH2_WDATA: regRdata <= ch2WriteData;
					`AXM_OFF_STATUS:    regRdata <= statusValue;
					default: begin
						if (sampleHit)
							regRdata <= externalSampleBytes[sampleOff[4:0]];
					end
				endcase
			end
		end
	end

	// command byte and code for each transfer phase
	always @* begin
		cmdCode = `AXM_CMD_STOP;
		txByte  = 8'h00;
		case (state)
			S_START, S_RSTART: cmdCode = `AXM_CMD_START;
			S_ADDR: begin
				cmdCode = `AXM_CMD_WRITE;
				// with register phase, first address is a write
				txByte  = {curId, curSkip ? curRead : 1'b0};
			end
			S_REG: begin
				cmdCode = `AXM_CMD_WRITE;
				txByte  = curStart;
			end
			S_RADDR: begin
				cmdCode = `AXM_CMD_WRITE;
				txByte  = {curId, 1'b1};
			end
			S_WDATA: begin
				cmdCode = `AXM_CMD_WRITE;
				txByte  = cur ? ch2WriteData : ch1WriteData;
			end
			S_DATA: cmdCode = `AXM_CMD_READ;
			default: cmdCode = `AXM_CMD_STOP;
		endcase
	end

	// channel sequencer
	always @(posedge mclk) begin
		if (sys_rst) begin
			state    <= S_IDLE;
			pending  <= 2'b00;
			cur      <= 1'b0;
			issued   <= 1'b0;
			cmdValid <= 1'b0;
			ackSend  <= 1'b0;
			curId    <= 7'h00;
			curRead  <= 1'b0;
			curStart <= 8'h00;
			curSwap  <= 1'b0;
			curSkip  <= 1'b0;
			curGrp   <= 1'b0;
			curCount <= 4'h0;
			curBase  <= 6'h00;
			byteIdx  <= 4'h0;
			for (i = 0; i < SAMPLE_DEPTH; i = i + 1)
				externalSampleBytes[i] <= 8'h00;
		end else begin
			cmdValid <= 1'b0;
			if (state != S_IDLE && state != S_SEL && !issued) begin
				cmdValid <= 1'b1;
				issued   <= 1'b1;
				ackSend  <= notLast;
			end
			if (engDone)
				issued <= 1'b0;
			case (state)
				S_IDLE: begin
					// only enabled channels run, once per sample
					if (samplePulse && (ch1Enable || ch2Enable)) begin
						pending <= {ch2Enable, ch1Enable};
						state   <= S_SEL;
					end
				end
				S_SEL: begin
					byteIdx <= 4'h0;
					if (pending[0]) begin
						pending[0] <= 1'b0;
						cur        <= 1'b0;
						curId      <= ch1TargetId;
						curRead    <= ch1ReadNotWrite;
						curStart   <= slave1StartRegister;
						curSwap    <= slave1ChannelControl[`AXM_BIT_SWAP];
						curSkip    <= slave1ChannelControl[`AXM_BIT_SKIPREG];
						curGrp     <= slave1ChannelControl[`AXM_BIT_GRP];
						curCount   <= ch1ByteCount;
						curBase    <= ch1Base;
						state      <= S_START;
					end else if (pending[1]) begin
						pending[1] <= 1'b0;
						cur        <= 1'b1;
						curId      <= ch2TargetId;
						curRead    <= ch2ReadNotWrite;
						curStart   <= slave2StartRegister;
						curSwap    <= slave2ChannelControl[`AXM_BIT_SWAP];
						curSkip    <= slave2ChannelControl[`AXM_BIT_SKIPREG];
						curGrp     <= slave2ChannelControl[`AXM_BIT_GRP];
						curCount   <= ch2ByteCount;
						curBase    <= ch2Base;
						state      <= S_START;
					end else begin
						state <= S_IDLE;
					end
				end
				S_START: if (engDone) state <= S_ADDR;
				S_ADDR: begin
					if (engDone) begin
						if (!ackSeen)
							state <= S_STOP;
						else if (!curSkip)
							state <= S_REG;
						else if (!curRead)
							state <= S_WDATA;
						else
							state <= (curCount == 4'h0) ? S_STOP : S_DATA;
					end
				end
				S_REG: begin
					if (engDone) begin
						if (!ackSeen)
							state <= S_STOP;
						else
							state <= curRead ? S_RSTART : S_WDATA;
					end
				end
				S_RSTART: if (engDone) state <= S_RADDR;
				S_RADDR: begin
					if (engDone) begin
						if (!ackSeen || curCount == 4'h0)
							state <= S_STOP;
						else
							state <= S_DATA;
					end
				end
				S_DATA: begin
					if (engDone) begin
						// store at swapped or in-order position
						if (destIdx < SAMPLE_DEPTH)
							externalSampleBytes[destIdx[4:0]] <= rxByte;
						byteIdx <= byteIdx + 4'h1;
						if (!notLast)
							state <= S_STOP;
					end
				end
				S_WDATA: if (engDone) state <= S_STOP;
				S_STOP: if (engDone) state <= S_SEL;
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** testbench/axm_aux_channels_sva.sv ***
// assertion checker for the auxiliary channel block
`include "axm_consts.vh"
`default_nettype none
module axm_aux_channels_sva #(
	parameter [15:0] SCL_QUARTER  = 16'h0019,
	parameter        SAMPLE_DEPTH = 24
) (
	input wire logic       mclk,         // clock
	input wire logic       sys_rst,      // reset
	input wire logic [7:0] regAddr,      // address
	input wire logic [7:0] regWdata,     // write data
	input wire logic       regWrite,     // write strobe
	input wire logic       regRead,      // read strobe
	input wire logic [7:0] regRdata,     // read data
	input wire logic       samplePulse,  // sample tick
	input wire logic       ch0Enable,    // ch0 enable
	input wire logic [3:0] ch0ByteCount, // ch0 count
	input wire logic       sclIn,        // clock line
	input wire logic       sclOut,       // clock drive
	input wire logic       sclOe,        // clock pull
	input wire logic       sdaIn,        // data line
	input wire logic       sdaOut,       // data drive
	input wire logic       sdaOe         // data pull
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int START_WIN = 8 * SCL_QUARTER + 16;
	logic [7:0] shadow [0:5];
	logic [7:0] expRd;
	logic       prevScl;
	logic       prevSda;
	logic       busFree;
	wire        startNow = prevScl && sclIn && prevSda && !sdaIn;
	wire        stopNow  = prevScl && sclIn && !prevSda && sdaIn;
	wire        inCfg    = regAddr >= `AXM_OFF_CH1_ADDR && regAddr <= `AXM_OFF_CH2_CTRL;
	wire [7:0]  cfgIdx   = regAddr - `AXM_OFF_CH1_ADDR;
	wire        enAny    = shadow[2][`AXM_BIT_EN] || shadow[5][`AXM_BIT_EN];

	// bus free between stop and start
	always_ff @(posedge mclk) begin
		prevScl <= sclIn;
		prevSda <= sdaIn;
		expRd <= shadow[cfgIdx[2:0]];
		if (sys_rst) begin
			busFree <= 1'b1;
			for (int i = 0; i < 6; i++) shadow[i] <= `AXM_RST_ADDR;
		end else begin
			if (startNow || stopNow) busFree <= stopNow;
			if (regWrite && inCfg) shadow[cfgIdx[2:0]] <= regWdata;
		end
	end

	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	a_reset_quiet: assert property (disable iff (1'b0)
		sys_rst |=> !sclOe && !sdaOe && regRdata == 8'h00) else $error("busy after reset");
	a_rdata_zero: assert property (!regRead |=> regRdata == 8'h00)
		else $error("read data outside read slot");
	a_cfg_readback: assert property (regRead && inCfg |=> regRdata == expRd)
		else $error("config readback mismatch");
	a_unmapped_zero: assert property (regRead && regAddr inside {[8'h00:8'h27], [8'h2E:8'h48]}
		|=> regRdata == 8'h00) else $error("unmapped read not zero");
	a_start_soon: assert property (
		samplePulse && enAny && busFree |-> ##[1:START_WIN] startNow) else $error("no start");
	a_disabled_quiet: assert property (
		samplePulse && !enAny && busFree |=> !sdaOe [*8]) else $error("bus used while disabled");
	a_scl_free: assert property (busFree |-> !sclOe)
		else $error("clock pulled outside frame");
	a_drive_zero: assert property (!sclOut && !sdaOut) else $error("open drain value not 0");
endmodule

bind axm_aux_channels axm_aux_channels_sva #(
	.SCL_QUARTER  (SCL_QUARTER),
	.SAMPLE_DEPTH (SAMPLE_DEPTH)
) chk (
	.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
	.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
	.samplePulse(samplePulse), .ch0Enable(ch0Enable), .ch0ByteCount(ch0ByteCount),
	.sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
	.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe)
);
`default_nettype wire

// *** testbench/axm_i2c_target.sv ***
// behavioural i2c target holding a byte pattern
`default_nettype none
module axm_i2c_target #(
	parameter logic [6:0] ID   = 7'h10,
	parameter logic [7:0] BASE = 8'h00
) (
	input  wire logic       scl,     // clock line
	input  wire logic       sda,     // data line
	input  wire logic       stretch, // slow answers
	output var  logic       sdaLow,  // pull data low
	output var  logic       sclLow,  // pull clock low
	output var  logic [7:0] ptr,     // register pointer
	output var  logic [7:0] wByte,   // last byte written
	output var  int         starts,  // transfers addressed to us
	output var  int         regSets  // pointer writes
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh;
	logic [7:0] tx;
	int         bitn;
	int         byteIdx;
	logic       act;
	logic       rd;
	logic       mAck;
	initial begin
		{sdaLow, sclLow, act, rd, mAck} = 5'h00;
		{ptr, wByte, sh, tx} = 32'h0000_0000;
		{starts, regSets, bitn, byteIdx} = {64'h0, 32'h8, 32'h0};
	end
	always @(negedge sda) if (scl) begin
		{act, rd, bitn, byteIdx} = {1'b1, 1'b0, 32'd8, 32'd0};
	end
	always @(posedge sda) if (scl) act = 1'b0;
	always @(posedge scl) if (act) begin
		if (bitn == 8) mAck = !sda;
		else if (!rd) sh = {sh[6:0], sda};
	end
	always @(negedge scl) if (act) begin
		bitn = (bitn == 8) ? 0 : bitn + 1;
		sdaLow = 1'b0;
		if (bitn == 8) begin
			if (!rd && byteIdx == 0) begin
				{act, rd} = {sh[7:1] == ID, sh[0]};
				starts += act;
			end else if (!rd && byteIdx == 1) {ptr, regSets} = {sh, regSets + 1};
			else if (!rd) wByte = sh;
			sdaLow = act && !rd || act && byteIdx == 0;
			byteIdx++;
		end else if (bitn == 0 && rd) begin
			if (byteIdx > 1) {ptr, act} = {ptr + 8'h01, mAck};
			tx = BASE + ptr;
		end
		if (act && rd && bitn < 8) sdaLow = !tx[7 - bitn];
	end
	// released clock returns to the pull-up
	always @(negedge scl) if (stretch && act) begin
		sclLow = 1'b1;
		#300 sclLow = 1'b0;
	end
endmodule
`default_nettype wire

// *** testbench/axm_aux_channels_bench.sv ***
// testbench for the auxiliary i2c channel 1 and 2 block
`include "axm_consts.vh"
`default_nettype none
module axm_aux_channels_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] ID1 = 7'h1D;
	localparam logic [6:0] ID2 = 7'h2E;
	localparam logic [7:0] B1  = 8'h40;
	localparam logic [7:0] B2  = 8'h90;
	logic       mclk, sys_rst, regWrite, regRead, samplePulse, ch0Enable, stretch1;
	logic [7:0] regAddr, regWdata, regRdata, d, p0, t1Ptr, t1WByte, t2Ptr, t2WByte;
	logic [3:0] ch0ByteCount;
	logic       sclOut, sclOe, sdaOut, sdaOe, t1Scl, t1Sda, t2Scl, t2Sda;
	int         t1Starts, t1Regs, t2Starts, t2Regs, errCount, numChecks, s0, r0;
	logic [7:0] want [$];
	wire        scl = !(sclOe || t1Scl || t2Scl);
	wire        sda = !(sdaOe || t1Sda || t2Sda);

	axm_aux_channels #(.SCL_QUARTER(16'h0002)) dut (
		.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.samplePulse(samplePulse), .ch0Enable(ch0Enable), .ch0ByteCount(ch0ByteCount),
		.sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
		.sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
	axm_i2c_target #(.ID(ID1), .BASE(B1)) tgt1 (.scl(scl), .sda(sda), .stretch(stretch1),
		.sdaLow(t1Sda), .sclLow(t1Scl), .ptr(t1Ptr), .wByte(t1WByte),
		.starts(t1Starts), .regSets(t1Regs));
	axm_i2c_target #(.ID(ID2), .BASE(B2)) tgt2 (.scl(scl), .sda(sda), .stretch(1'b0),
		.sdaLow(t2Sda), .sclLow(t2Scl), .ptr(t2Ptr), .wByte(t2WByte),
		.starts(t2Starts), .regSets(t2Regs));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = !mclk;
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		numChecks++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		{regAddr, regWdata, regWrite} <= {a, v, 1'b1};
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		{regAddr, regRead} <= {a, 1'b1};
		@(posedge mclk);
		regRead <= 1'b0;
		// data registered at this edge, taken at the next
		@(posedge mclk);
		v = regRdata;
	endtask
	task automatic cfg(input int ch, input logic [7:0] a, input logic [7:0] r,
		input logic [7:0] c);
		wr(8'(`AXM_OFF_CH1_ADDR + 3 * (ch - 1)), a);
		wr(8'(`AXM_OFF_CH1_REG + 3 * (ch - 1)), r);
		wr(8'(`AXM_OFF_CH1_CTRL + 3 * (ch - 1)), c);
	endtask
	task automatic printVerdict();
		$display("checks %0d errors %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic runSample(input logic expBusy);
		@(posedge mclk);
		samplePulse <= 1'b1;
		@(posedge mclk);
		samplePulse <= 1'b0;
		rd(`AXM_OFF_STATUS, d);
		check("busy", {7'h00, expBusy}, {7'h00, d[`AXM_ST_BUSY]});
		for (int i = 0; i < 4000; i++) begin
			rd(`AXM_OFF_STATUS, d);
			if (d[`AXM_ST_BUSY] === 1'b0) return;
		end
		errCount++;
		$display("[ERR] busy expected 0 seen 1");
		printVerdict();
	endtask
	task automatic chkSamples(input int first);
		foreach (want[i]) begin
			rd(8'(`AXM_OFF_SAMPLE_BASE + first + i), d);
			check("sample byte", want[i], d);
		end
	endtask

	initial begin
		{sys_rst, regWrite, regRead, samplePulse, ch0Enable, stretch1} = 6'b100000;
		{regAddr, regWdata, ch0ByteCount} = 20'h00000;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(8'(`AXM_OFF_CH1_ADDR + i), d);
			check("reset value", `AXM_RST_ADDR, d);
			wr(8'(`AXM_OFF_CH1_ADDR + i), 8'(8'h13 * (i + 1)));
			rd(8'(`AXM_OFF_CH1_ADDR + i), d);
			check("readback", 8'(8'h13 * (i + 1)), d);
		end
		wr(8'h20, 8'h5A);
		rd(8'h20, d);
		check("unmapped", 8'h00, d);
		// swap around a channel 0 region
		{ch0Enable, ch0ByteCount} <= 5'h13;
		cfg(1, {1'b1, ID1}, 8'h01, 8'hC4);
		cfg(2, {1'b1, ID2}, 8'h10, 8'h82);
		runSample(1'b1);
		want = {8'h00, B1 + 8'h01, B1 + 8'h03, B1 + 8'h02, B1 + 8'h04, B2 + 8'h10, B2 + 8'h11, 8'h00};
		chkSamples(2);
		// odd alignment, channel 1 off
		ch0Enable <= 1'b0;
		cfg(1, {1'b1, ID1}, 8'h00, 8'h04);
		cfg(2, {1'b1, ID2}, 8'h01, 8'hD4);
		s0 = t1Starts;
		runSample(1'b1);
		check("ch1 starts", 8'(s0), 8'(t1Starts));
		want = {B2 + 8'h02, B2 + 8'h01, B2 + 8'h04, B2 + 8'h03};
		chkSamples(0);
		// no register address phase
		cfg(2, {1'b1, ID2}, 8'h01, 8'hA1);
		{s0, r0, p0} = {t2Starts, t2Regs, t2Ptr};
		runSample(1'b1);
		check("ch2 starts", 8'(s0 + 1), 8'(t2Starts));
		check("ch2 pointer writes", 8'(r0), 8'(t2Regs));
		want = {B2 + p0};
		chkSamples(0);
		// write transfer to a stretching target
		stretch1 <= 1'b1;
		wr(`AXM_OFF_CH1_WDATA, 8'hA5);
		cfg(2, {1'b1, ID2}, 8'h00, 8'h00);
		cfg(1, {1'b0, ID1}, 8'h33, 8'h81);
		runSample(1'b1);
		check("written byte", 8'hA5, t1WByte);
		check("written pointer", 8'h33, t1Ptr);
		wr(`AXM_OFF_CH1_CTRL, 8'h00);
		s0 = t1Starts + t2Starts;
		runSample(1'b0);
		check("idle starts", 8'(s0), 8'(t1Starts + t2Starts));
		// absent target: address nack ends the frame, flag sticks until cleared
		cfg(1, 8'h55, 8'h00, 8'h81);
		runSample(1'b1);
		rd(`AXM_OFF_STATUS, d);
		check("nack flag", 8'h02, d);
		wr(`AXM_OFF_STATUS, 8'h02);
		rd(`AXM_OFF_STATUS, d);
		check("nack cleared", 8'h00, d);
		printVerdict();
	end
endmodule
`default_nettype wire
